// File: dv/cwd_bus_model.sv
/*
  stand-in for the can bus and the other nodes facing the transceiver block.
  assumes the bench picks the short kind and other-node dominant traffic.
*/
`timescale 1ns/1ps
module cwd_bus_model (
  // from the block
  input  wire logic       i_drv_en,
  input  wire logic       i_drv_dominant,
  // bench commands
  input  wire logic [2:0] i_short,
  input  wire logic       i_ext_dom,
  // to the block
  output logic            o_bus_dominant,
  output logic            o_wake_dominant,
  output logic            o_lo_gnd,
  output logic            o_hi_gnd,
  output logic            o_lo_bat,
  output logic            o_hi_bat,
  output logic            o_lo_rail,
  output logic            o_hi_rail
);
  logic dom;  // our driver pulls dominant

  assign dom = i_drv_en & i_drv_dominant;
  // wired dominant of all nodes
  assign o_bus_dominant  = dom | i_ext_dom;
  assign o_wake_dominant = i_ext_dom;

  // comparator levels per short and driver state
  always_comb begin
    o_lo_gnd  = ~dom;
    o_hi_gnd  = 1'h1;
    o_lo_bat  = 1'h0;
    o_hi_bat  = 1'h0;
    o_lo_rail = 1'h0;
    o_hi_rail = 1'h0;
    case (i_short)
      cwd_pkg::CWD_F_L_GND: begin
        o_lo_gnd = 1'h0;
        o_hi_gnd = dom;
      end
      cwd_pkg::CWD_F_H_GND: begin
        o_lo_gnd = 1'h0;
        o_hi_gnd = 1'h0;
      end
      cwd_pkg::CWD_F_L_BAT: begin
        o_lo_bat = 1'h1;
        o_hi_bat = dom;
      end
      cwd_pkg::CWD_F_H_BAT: begin
        o_lo_bat = ~dom;
        o_hi_bat = 1'h1;
      end
      cwd_pkg::CWD_F_L_5V: begin
        o_lo_rail = 1'h1;
        o_hi_rail = 1'h1;
      end
      cwd_pkg::CWD_F_H_5V: begin
        o_lo_rail = ~dom;
        o_hi_rail = 1'h1;
      end
      default: begin  // healthy bus
      end
    endcase
  end
endmodule // cwd_bus_model

// File: dv/cwd_top_tb.sv
/*
  self-checking bench for the can transceiver mode, wake and fault block.
  assumes the block samples inputs on each rising edge of a 100 MHz clock.
*/
`timescale 1ns/1ps
module cwd_top_tb;
  logic        i_clk, i_rst_n, slew_load, wake_en, pulse_sel, low_pwr, fclr, txd, smp_ready, ext_dom;
  logic [1:0]  mode, slew_sel;
  logic [2:0]  short_kind;
  logic        bus_dom, wake_dom, lg, hg, lb, hb, l5, h5;
  logic        o_rxd, o_drv_en, o_drv_dominant, o_rx_en, o_rin_to_gnd, o_split_en, o_smp_valid, o_smp_data;
  logic        o_wake_flag, o_wake_int, o_wake_device, o_txd_perm_flag, o_fault_flag;
  logic [1:0]  o_slew;
  logic [2:0]  o_fault;
  int          error_cnt, check_count, int_cnt, pops, zeros;

  // 100 MHz clock
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  cwd_top i_cwd_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(mode), .i_slew_sel(slew_sel), .i_slew_load(slew_load),
    .i_wake_en(wake_en), .i_wake_pulse_select(pulse_sel), .i_low_power(low_pwr), .i_flag_clear(fclr),
    .i_txd(txd), .o_rxd(o_rxd), .i_bus_dominant(bus_dom), .i_wake_dominant(wake_dom),
    .i_low_line_ground_comparator(lg), .i_high_line_ground_comparator(hg),
    .i_low_line_battery_comparator(lb), .i_high_line_battery_comparator(hb),
    .i_low_line_five_volt_comparator(l5), .i_high_line_five_volt_comparator(h5),
    .o_drv_en(o_drv_en), .o_drv_dominant(o_drv_dominant), .o_rx_en(o_rx_en), .o_rin_to_gnd(o_rin_to_gnd),
    .o_split_en(o_split_en), .o_slew(o_slew), .o_smp_valid(o_smp_valid), .o_smp_data(o_smp_data),
    .i_smp_ready(smp_ready), .o_wake_flag(o_wake_flag), .o_wake_int(o_wake_int),
    .o_wake_device(o_wake_device), .o_txd_perm_flag(o_txd_perm_flag), .o_fault(o_fault),
    .o_fault_flag(o_fault_flag));

  cwd_bus_model i_cwd_bus_model (
    .i_drv_en(o_drv_en), .i_drv_dominant(o_drv_dominant), .i_short(short_kind), .i_ext_dom(ext_dom),
    .o_bus_dominant(bus_dom), .o_wake_dominant(wake_dom), .o_lo_gnd(lg), .o_hi_gnd(hg),
    .o_lo_bat(lb), .o_hi_bat(hb), .o_lo_rail(l5), .o_hi_rail(h5));

  // count interrupt pulse cycles away from the edge
  always @(negedge i_clk) begin
    if (o_wake_int === 1'h1) int_cnt++;
  end

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one dominant pulse from another node
  task automatic pulse(input int w, input int gap);
    ext_dom = 1'h1;
    tick(w);
    ext_dom = 1'h0;
    tick(gap);
  endtask

  // short recessive-dominant cycles, well under the timeout
  task automatic edges(input int n);
    repeat (n) begin
      txd = 1'h1;
      tick(4);
      txd = 1'h0;
      tick(4);
    end
    txd = 1'h1;
  endtask

  // flag clear as a one-cycle read
  task automatic clear_flags;
    fclr = 1'h1;
    tick(1);
    fclr = 1'h0;
    tick(1);
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, about twice the expected run
  initial begin
    #1000000;
    error_cnt++;
    finish_test();
  end

  initial begin
    {i_rst_n, slew_load, wake_en, pulse_sel, low_pwr, fclr, smp_ready, ext_dom} = 8'h00;
    {mode, slew_sel, short_kind} = 7'h00;
    txd = 1'h1;
    tick(5);
    i_rst_n = 1'h1;
    tick(1);
    chk("drv_en", 1'h0, o_drv_en);
    chk("rin_to_gnd", 1'h1, o_rin_to_gnd);
    chk("rxd", 1'h1, o_rxd);
    chk("slew", 2'h0, o_slew);
    chk("flags", 3'h0, {o_wake_flag, o_txd_perm_flag, o_fault_flag});
    // slew loads, code 3 ignored
    for (int s = 1; s < 4; s++) begin
      slew_sel = 2'(s);
      slew_load = 1'h1;
      tick(1);
      slew_load = 1'h0;
      tick(1);
      chk("slew", (s == 3) ? 16'h2 : 16'(s), o_slew);
    end
    txd = 1'h0;
    mode = cwd_pkg::CWD_MODE_NORMAL;
    tick(4);
    chk("drv_en", 1'h0, o_drv_en);
    txd = 1'h1;
    tick(3);
    chk("drv_en", 1'h1, o_drv_en);
    txd = 1'h0;
    tick(3);
    chk("drv_dominant", 1'h1, o_drv_dominant);
    chk("rxd", 1'h0, o_rxd);
    txd = 1'h1;
    tick(3);
    chk("drv_dominant", 1'h0, o_drv_dominant);
    chk("rxd", 1'h1, o_rxd);
    mode = cwd_pkg::CWD_MODE_RXONLY;
    txd = 1'h0;
    tick(3);
    chk("drv_en", 1'h0, o_drv_en);
    chk("rx_en", 1'h1, o_rx_en);
    chk("rxd", 1'h1, o_rxd);
    ext_dom = 1'h1;
    tick(3);
    chk("rxd", 1'h0, o_rxd);
    ext_dom = 1'h0;
    txd = 1'h1;
    mode = cwd_pkg::CWD_MODE_NORMAL;
    tick(3);
    // every short kind, reported at the fifth cycle only
    for (int f = 1; f < 7; f++) begin
      short_kind = 3'(f);
      clear_flags();
      edges(4);
      chk("fault_flag", 1'h0, o_fault_flag);
      edges(1);
      tick(3);
      chk("fault_flag", 1'h1, o_fault_flag);
      chk("fault", 16'(f), o_fault);
    end
    short_kind = 3'h0;
    clear_flags();
    chk("fault_flag", 1'h0, o_fault_flag);
    // stuck transmit input
    txd = 1'h0;
    tick(29000);
    chk("txd_perm", 1'h0, o_txd_perm_flag);
    chk("drv_en", 1'h1, o_drv_en);
    tick(1100);
    chk("txd_perm", 1'h1, o_txd_perm_flag);
    chk("drv_en", 1'h0, o_drv_en);
    txd = 1'h1;
    clear_flags();
    mode = cwd_pkg::CWD_MODE_RXONLY;
    tick(2);
    mode = cwd_pkg::CWD_MODE_NORMAL;
    tick(3);
    chk("drv_en", 1'h1, o_drv_en);
    chk("txd_perm", 1'h0, o_txd_perm_flag);
    // sleep stops pushes; fifo and output register drain
    mode = cwd_pkg::CWD_MODE_SLEEP;
    tick(3);
    chk("drv_en", 1'h0, o_drv_en);
    chk("rin_to_gnd", 1'h1, o_rin_to_gnd);
    chk("split_en", 1'h0, o_split_en);
    smp_ready = 1'h1;
    pops = 0;
    zeros = 0;
    // ready held high: each shown cycle is taken at the next edge
    repeat (40) begin
      if (o_smp_valid === 1'h1) pops++;
      if (o_smp_valid === 1'h1 && o_smp_data === 1'h0) zeros++;
      tick(1);
    end
    // sixteen fifo words plus the output register
    chk("pops", 16'h11, 16'(pops));
    // three driven dominant samples, one from another node
    chk("smp_zeros", 16'h4, 16'(zeros));
    // wake disabled, then too-short pulses
    repeat (3) pulse(100, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    wake_en = 1'h1;
    tick(2);
    repeat (3) pulse(40, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    low_pwr = 1'h1;
    int_cnt = 0;
    repeat (2) pulse(100, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    pulse(100, 100);
    chk("wake_flag", 1'h1, o_wake_flag);
    chk("wake_device", 1'h1, o_wake_device);
    chk("wake_int", 16'h1, 16'(int_cnt));
    // window expiry restarts the count
    low_pwr = 1'h0;
    clear_flags();
    pulse(100, 100);
    pulse(100, 13000);
    repeat (2) pulse(100, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    pulse(100, 100);
    chk("wake_flag", 1'h1, o_wake_flag);
    // leaving sleep drops counted pulses
    clear_flags();
    repeat (2) pulse(100, 100);
    mode = cwd_pkg::CWD_MODE_RXONLY;
    tick(3);
    mode = cwd_pkg::CWD_MODE_SLEEP;
    tick(3);
    pulse(100, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    // single pulse wake
    pulse_sel = 1'h1;
    clear_flags();
    pulse(150, 100);
    chk("wake_flag", 1'h0, o_wake_flag);
    pulse(250, 100);
    chk("wake_flag", 1'h1, o_wake_flag);
    // back to normal, lines recessive
    mode = cwd_pkg::CWD_MODE_NORMAL;
    tick(4);
    chk("rin_to_gnd", 1'h0, o_rin_to_gnd);
    chk("drv_en", 1'h1, o_drv_en);
    chk("drv_dominant", 1'h0, o_drv_dominant);
    chk("rxd", 1'h1, o_rxd);
    finish_test();
  end
endmodule // cwd_top_tb

// File: hw/cwd_cfg.svh
/*
  constants for the can transceiver mode, wake and diagnostic block.
  assumes one 100 MHz clock and a synchronous active-low reset.
*/
// What this block does
// R1: normal mode drives bus, reports receive
// R2: receive-only disables driver, ignores transmit
// R3: driver enables only after recessive transmit
// R4: transmit high recessive, low dominant
// R5: receive high recessive, low dominant
// R6: three slew rates, fastest after reset
// R7: controller keeps at least 40 kBaud
// R8: sleep disables drivers, grounds inputs
// R9: bus wake sets flag, pulses interrupt
// R10: leaving sleep restores recessive lines
// R11: software enables or disables bus wake
// R12: pattern wake needs three valid pulses
// R13: single-pulse mode wakes after 2 us
// R14: valid pattern pulse exceeds 500 ns
// R15: three pulses fit in 120 us
// R16: ground shorts classified from ground comparators
// R17: battery shorts classified from battery comparators
// R18: five-volt shorts classified from rail comparators
// R19: combine comparators with driver state, flag
// R20: report fault after five consistent cycles
// R21: transmit dominant timeout disables driver
// R22: software clears flags, reselects normal mode
// R23: window expiry discards counted wake pulses
// R24: wake counters reset on sleep entry
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH
`define CWD_CLK_MHZ       100
`define CWD_PULSE_NS      500
`define CWD_PULSE_CYC     ((`CWD_PULSE_NS * `CWD_CLK_MHZ + 999) / 1000)
`define CWD_SINGLE_NS     2000
`define CWD_SINGLE_CYC    ((`CWD_SINGLE_NS * `CWD_CLK_MHZ + 999) / 1000)
`define CWD_WINDOW_US     120
`define CWD_WINDOW_CYC    (`CWD_WINDOW_US * `CWD_CLK_MHZ)
`define CWD_TDOUT_US      300
`define CWD_TDOUT_CYC     (`CWD_TDOUT_US * `CWD_CLK_MHZ)
`define CWD_WAKE_PULSES   3
`define CWD_FAULT_CYCLES  5
`define CWD_SLEW_RESET    2'h0
`define CWD_FIFO_DEPTH    16
`endif

// File: hw/cwd_fifo.sv
/*
  small valid/ready fifo for received bus samples.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module cwd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // write side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // read side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  // state
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } cwd_fifo_st_t;
  cwd_fifo_st_t st;
  cwd_fifo_st_t next_st;
  logic push;
  logic pop;
  // handshakes
  always_comb begin
    push    = i_in_valid && (st.cnt != (AW+1)'(DEPTH));
    pop     = i_out_ready && (st.cnt != '0);
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  // register state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // memory write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[st.wr] <= i_in_data;
    end
  end
  assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data  = mem[st.rd];
endmodule // cwd_fifo

// File: hw/cwd_pkg.sv
/*
  types shared by the can transceiver block.
  assumes cwd_cfg.svh is compiled alongside.
*/
package cwd_pkg;
  // requested transceiver mode
  typedef enum logic [1:0] {
    CWD_MODE_SLEEP  = 2'h0,
    CWD_MODE_RXONLY = 2'h1,
    CWD_MODE_NORMAL = 2'h2
  } cwd_mode_t;
  // driver state machine, one-hot
  typedef enum logic [3:0] {
    CWD_DRV_OFF   = 4'h1,
    CWD_DRV_WAIT  = 4'h2,
    CWD_DRV_ON    = 4'h4,
    CWD_DRV_FAULT = 4'h8
  } cwd_drv_t;
  // classified bus fault
  typedef enum logic [2:0] {
    CWD_F_NONE = 3'h0,
    CWD_F_L_GND = 3'h1,
    CWD_F_H_GND = 3'h2,
    CWD_F_L_BAT = 3'h3,
    CWD_F_H_BAT = 3'h4,
    CWD_F_L_5V  = 3'h5,
    CWD_F_H_5V  = 3'h6
  } cwd_fault_t;
endpackage

// File: hw/cwd_top.sv
/*
  can transceiver mode control, bus wake detection and bus fault diagnosis.
  assumes comparator and receiver inputs synchronous to the 100 MHz clock.
*/
`timescale 1ns/1ps
`include "cwd_cfg.svh"
module cwd_top (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // configuration
  input  wire logic [1:0] i_mode,
  input  wire logic [1:0] i_slew_sel,
  input  wire logic       i_slew_load,
  input  wire logic       i_wake_en,
  input  wire logic       i_wake_pulse_select,
  input  wire logic       i_low_power,
  input  wire logic       i_flag_clear,
  // controller side
  input  wire logic       i_txd,
  output logic            o_rxd,
  // analog front end
  input  wire logic       i_bus_dominant,
  input  wire logic       i_wake_dominant,
  input  wire logic       i_low_line_ground_comparator,
  input  wire logic       i_high_line_ground_comparator,
  input  wire logic       i_low_line_battery_comparator,
  input  wire logic       i_high_line_battery_comparator,
  input  wire logic       i_low_line_five_volt_comparator,
  input  wire logic       i_high_line_five_volt_comparator,
  output logic            o_drv_en,
  output logic            o_drv_dominant,
  output logic            o_rx_en,
  output logic            o_rin_to_gnd,
  output logic            o_split_en,
  output logic [1:0]      o_slew,
  // sample stream out
  output logic            o_smp_valid,
  output logic            o_smp_data,
  input  wire logic       i_smp_ready,
  // status
  output logic            o_wake_flag,
  output logic            o_wake_int,
  output logic            o_wake_device,
  output logic            o_txd_perm_flag,
  output logic [2:0]      o_fault,
  output logic            o_fault_flag
);
  localparam logic [15:0] PULSE_CYC  = 16'(`CWD_PULSE_CYC);
  localparam logic [15:0] SINGLE_CYC = 16'(`CWD_SINGLE_CYC);
  localparam logic [15:0] WIN_CYC    = 16'(`CWD_WINDOW_CYC);
  localparam logic [15:0] TDOUT_CYC  = 16'(`CWD_TDOUT_CYC);
  localparam logic [1:0]  NPULSE     = 2'(`CWD_WAKE_PULSES);
  localparam logic [2:0]  NFAULT     = 3'(`CWD_FAULT_CYCLES);

  // classify comparator readings by driver state
  function automatic cwd_pkg::cwd_fault_t classify(input logic dom, input logic lg, input logic hg,
      input logic lb, input logic hb, input logic l5, input logic h5);
    cwd_pkg::cwd_fault_t f;
    f = cwd_pkg::CWD_F_NONE;
    if (!dom) begin
      if (l5 && h5) begin
        f = cwd_pkg::CWD_F_H_5V;
      end else if (lb && hb) begin
        f = cwd_pkg::CWD_F_H_BAT;
      end else if (lb) begin
        f = cwd_pkg::CWD_F_L_BAT;
      end else if (!lg && !hg) begin
        f = cwd_pkg::CWD_F_L_GND;
      end
    end else begin
      if (l5 && h5) begin
        f = cwd_pkg::CWD_F_L_5V;
      end else if (h5) begin
        f = cwd_pkg::CWD_F_H_5V;
      end else if (lb && hb) begin
        f = cwd_pkg::CWD_F_L_BAT;
      end else if (hb) begin
        f = cwd_pkg::CWD_F_H_BAT;
      end else if (!hg) begin
        f = cwd_pkg::CWD_F_H_GND;
      end else if (!lg && hg) begin
        f = cwd_pkg::CWD_F_NONE;
      end
    end
    return f;
  endfunction

  // block state apart from the output registers and the sample fifo
  typedef struct packed {
    cwd_pkg::cwd_drv_t   drv;
    logic [1:0]          slew;
    logic                prev_mode_sleep;
    logic                prev_wake_dom;
    logic [15:0]         pulse_cnt;
    logic [15:0]         win_cnt;
    logic                win_open;
    logic [1:0]          npulse;
    logic [15:0]         dom_cnt;
    logic                txd_perm;
    logic                wake_flag;
    logic                wake_int;
    logic                wake_dev;
    logic                rxd;
    logic                drv_dom;
    logic                prev_dom;
    cwd_pkg::cwd_fault_t rec_fault;
    cwd_pkg::cwd_fault_t cand;
    logic [2:0]          cyc;
    cwd_pkg::cwd_fault_t fault;
    logic                fault_flag;
  } cwd_st_t;
  cwd_st_t st;
  cwd_st_t next_st;

  // sample fifo
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_take;       // output register free or being taken
  cwd_fifo #(.WIDTH(1), .DEPTH(`CWD_FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (o_rx_en),
    .i_in_data   (st.rxd),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_take)
  );
  // pop only into an empty or draining output register
  assign fifo_take = !o_smp_valid || i_smp_ready;

  logic                is_sleep;
  logic                is_normal;
  logic                wake_hit;
  logic                pulse_end;
  logic                fault_hit;  // fault report this cycle
  logic                tdout_hit;  // dominant timeout this cycle
  cwd_pkg::cwd_fault_t now_f;

  // next-state logic
  always_comb begin
    next_st   = st;
    is_sleep  = (i_mode == cwd_pkg::CWD_MODE_SLEEP);
    is_normal = (i_mode == cwd_pkg::CWD_MODE_NORMAL);
    wake_hit  = 1'b0;
    pulse_end = 1'b0;
    fault_hit = 1'b0;
    tdout_hit = 1'b0;
    now_f     = cwd_pkg::CWD_F_NONE;
    next_st.prev_mode_sleep = is_sleep;
    next_st.prev_wake_dom   = i_wake_dominant;
    next_st.wake_int        = 1'b0;
    // R6: slew select, fastest from reset
    if (i_slew_load && i_slew_sel != 2'h3) begin
      next_st.slew = i_slew_sel;
    end
    // R5: receive follows differential state
    next_st.rxd = is_sleep ? 1'b1 : !i_bus_dominant;
    // driver machine
    case (st.drv)
      cwd_pkg::CWD_DRV_OFF: begin
        if (is_normal) begin
          next_st.drv = cwd_pkg::CWD_DRV_WAIT;
        end
      end
      cwd_pkg::CWD_DRV_WAIT: begin
        // R3: enable on recessive transmit only
        if (!is_normal) begin
          next_st.drv = cwd_pkg::CWD_DRV_OFF;
        end else if (i_txd) begin
          next_st.drv = cwd_pkg::CWD_DRV_ON;
        end
      end
      cwd_pkg::CWD_DRV_ON: begin
        // R2: leaving normal drops the driver
        if (!is_normal) begin
          next_st.drv = cwd_pkg::CWD_DRV_OFF;
        end else if (!i_txd && st.dom_cnt >= TDOUT_CYC - 16'h0001) begin
          // R21: dominant timeout releases bus
          next_st.drv      = cwd_pkg::CWD_DRV_FAULT;
          next_st.txd_perm = 1'b1;
          tdout_hit        = 1'b1;
        end
      end
      cwd_pkg::CWD_DRV_FAULT: begin
        // R22: recover when software reselects normal
        if (!is_normal) begin
          next_st.drv = cwd_pkg::CWD_DRV_OFF;
        end
      end
      default: begin
        next_st.drv = cwd_pkg::CWD_DRV_OFF;
      end
    endcase
    // dominant length counter
    if (st.drv == cwd_pkg::CWD_DRV_ON && !i_txd) begin
      next_st.dom_cnt = st.dom_cnt + 16'h0001;
    end else begin
      next_st.dom_cnt = 16'h0000;
    end
    // R4: low transmit drives dominant, R10 recessive otherwise
    next_st.drv_dom = (next_st.drv == cwd_pkg::CWD_DRV_ON) && !i_txd;
    // R24: wake counters cleared on sleep entry
    if (!is_sleep || !st.prev_mode_sleep) begin
      next_st.pulse_cnt = 16'h0000;
      next_st.win_cnt   = 16'h0000;
      next_st.win_open  = 1'b0;
      next_st.npulse    = 2'h0;
    end else if (i_wake_en) begin
      // R11: wake detection only when enabled
      if (i_wake_dominant) begin
        next_st.pulse_cnt = (st.pulse_cnt == 16'hFFFF) ? st.pulse_cnt : st.pulse_cnt + 16'h0001;
      end else begin
        next_st.pulse_cnt = 16'h0000;
      end
      pulse_end = st.prev_wake_dom && !i_wake_dominant;
      if (i_wake_pulse_select) begin
        // R13: single long pulse
        wake_hit = i_wake_dominant && (st.pulse_cnt == SINGLE_CYC - 16'h0001);
      end else begin
        // R15: window runs from first valid pulse
        if (st.win_open) begin
          next_st.win_cnt = st.win_cnt + 16'h0001;
        end
        // R23: expiry discards counted pulses
        if (st.win_open && st.win_cnt >= WIN_CYC - 16'h0001) begin
          next_st.win_open = 1'b0;
          next_st.win_cnt  = 16'h0000;
          next_st.npulse   = 2'h0;
        end else if (pulse_end && st.pulse_cnt > PULSE_CYC) begin
          // R14: only pulses above 500 ns count
          // R12: third valid pulse wakes
          if (st.npulse == NPULSE - 2'h1) begin
            wake_hit         = 1'b1;
            next_st.npulse   = 2'h0;
            next_st.win_open = 1'b0;
            next_st.win_cnt  = 16'h0000;
          end else begin
            next_st.npulse   = st.npulse + 2'h1;
            next_st.win_open = 1'b1;
          end
        end
      end
    end
    // R9: flag, interrupt pulse, device wake
    if (wake_hit) begin
      next_st.wake_flag = 1'b1;
      next_st.wake_int  = 1'b1;
      next_st.wake_dev  = i_low_power;
    end else if (i_flag_clear) begin
      next_st.wake_flag = 1'b0;
      next_st.wake_dev  = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (i_flag_clear && !tdout_hit) begin
      next_st.txd_perm = 1'b0;
    end
    // R16: R17: R18: R19: classify per driver state
    now_f = classify(st.drv_dom, i_low_line_ground_comparator, i_high_line_ground_comparator,
                     i_low_line_battery_comparator, i_high_line_battery_comparator,
                     i_low_line_five_volt_comparator, i_high_line_five_volt_comparator);
    next_st.prev_dom = st.drv_dom;
    if (st.drv == cwd_pkg::CWD_DRV_ON) begin
      if (!st.drv_dom) begin
        next_st.rec_fault = now_f;
      end
      // R20: five matching recessive-dominant cycles
      if (st.drv_dom && !st.prev_dom) begin
        if (st.rec_fault != cwd_pkg::CWD_F_NONE && now_f == cwd_pkg::CWD_F_NONE) begin
          now_f = st.rec_fault;
        end
        if (now_f == cwd_pkg::CWD_F_NONE || now_f != st.cand) begin
          next_st.cand = now_f;
          next_st.cyc  = (now_f == cwd_pkg::CWD_F_NONE) ? 3'h0 : 3'h1;
        end else if (st.cyc < NFAULT) begin
          next_st.cyc = st.cyc + 3'h1;
        end
        if (now_f != cwd_pkg::CWD_F_NONE && now_f == st.cand && st.cyc == NFAULT - 3'h1) begin
          next_st.fault      = now_f;
          next_st.fault_flag = 1'b1;
          fault_hit          = 1'b1;
        end
      end
    end
    // a new report wins over a clear
    if (i_flag_clear && !fault_hit) begin
      next_st.fault_flag = 1'b0;
      next_st.fault      = cwd_pkg::CWD_F_NONE;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st      <= '0;
      st.drv  <= cwd_pkg::CWD_DRV_OFF;
      st.slew <= `CWD_SLEW_RESET;
      st.rxd  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // output registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_drv_en       <= 1'b0;
      o_drv_dominant <= 1'b0;
      o_rx_en        <= 1'b0;
      o_rin_to_gnd   <= 1'b1;
      o_split_en     <= 1'b0;
      o_smp_valid    <= 1'b0;
      o_smp_data     <= 1'b1;
    end else begin
      // R1: driver and receiver in normal
      o_drv_en       <= (next_st.drv == cwd_pkg::CWD_DRV_ON);
      o_drv_dominant <= next_st.drv_dom;
      // R8: sleep grounds inputs, split off
      o_rx_en        <= (i_mode != cwd_pkg::CWD_MODE_SLEEP);
      o_rin_to_gnd   <= (i_mode == cwd_pkg::CWD_MODE_SLEEP);
      o_split_en     <= (i_mode != cwd_pkg::CWD_MODE_SLEEP);
      // hold a shown sample until it is taken
      if (fifo_take) begin
        o_smp_valid  <= fifo_out_valid;
        o_smp_data   <= fifo_out_data;
      end
    end
  end
  assign o_rxd           = st.rxd;
  assign o_slew          = st.slew;
  assign o_wake_flag     = st.wake_flag;
  assign o_wake_int      = st.wake_int;
  assign o_wake_device   = st.wake_dev;
  assign o_txd_perm_flag = st.txd_perm;
  assign o_fault         = st.fault;
  assign o_fault_flag    = st.fault_flag;

  // assertions
  AST_DRV_NORMAL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    o_drv_en |-> $past(i_mode) == cwd_pkg::CWD_MODE_NORMAL) else $error("driver on outside normal");
  AST_DRV_RECESSIVE_START: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    (st.drv == cwd_pkg::CWD_DRV_WAIT && !i_txd) |=> st.drv != cwd_pkg::CWD_DRV_ON) else $error("enabled on dominant");
  AST_TX_FOLLOW: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    (next_st.drv == cwd_pkg::CWD_DRV_ON && !i_txd) |=> o_drv_dominant) else $error("dominant not driven");
  AST_RXD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
    (i_mode != cwd_pkg::CWD_MODE_SLEEP && i_bus_dominant) |=> !o_rxd) else $error("rxd not low");
  AST_SLEEP_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    (i_mode == cwd_pkg::CWD_MODE_SLEEP) |=> (!o_drv_en && o_rin_to_gnd && !o_split_en)) else $error("sleep drive");
  AST_WAKE_INT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
    $rose(o_wake_int) |-> o_wake_flag) else $error("int without flag");
  AST_WAKE_DIS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    !i_wake_en |=> !o_wake_int) else $error("wake while disabled");
  AST_TDOUT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R21
    (st.dom_cnt == TDOUT_CYC - 16'h0001 && !i_txd && i_mode == cwd_pkg::CWD_MODE_NORMAL) |=> o_txd_perm_flag)
    else $error("timeout missed");
  AST_FAULT_COUNT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    $rose(o_fault_flag) |-> $past(st.cyc) == NFAULT - 3'h1) else $error("fault early");
  COV_WAKE: cover property (@(posedge i_clk) o_wake_int);
  COV_FAULT: cover property (@(posedge i_clk) o_fault_flag);
  COV_TDOUT: cover property (@(posedge i_clk) $rose(o_txd_perm_flag));
endmodule // cwd_top
